// ### src/pru_pkg.sv
// constants and types of the prefixed rotate unit
`default_nettype none
package pru_pkg;
   localparam logic [7:0] PRU_PFX_CB = 8'hcb;
   localparam logic [7:0] PRU_PFX_IX = 8'hdd;
   localparam logic [7:0] PRU_PFX_IY = 8'hfd;
   localparam logic [4:0] PRU_OP_RLC = 5'h00;
   localparam logic [4:0] PRU_OP_RRC = 5'h01;
   localparam logic [4:0] PRU_OP_RL = 5'h02;
   localparam logic [2:0] PRU_REG_MEM = 3'h6;
   // flag bit positions
   localparam int PRU_F_S = 7;
   localparam int PRU_F_Z = 6;
   localparam int PRU_F_H = 4;
   localparam int PRU_F_PV = 2;
   localparam int PRU_F_N = 1;
   localparam int PRU_F_C = 0;
   localparam logic [7:0] PRU_FLAGS_RST = 8'h00;
   localparam logic [15:0] PRU_PTR_RST = 16'h0000;
   // clock states per machine cycle along each form
   localparam logic [2:0] PRU_T_M1 = 3'h4;
   localparam logic [2:0] PRU_T_MEMRD = 3'h3;
   localparam logic [2:0] PRU_T_DISP_ADD = 3'h5;
   localparam logic [2:0] PRU_T_PAIR_RD = 3'h4;
   localparam logic [2:0] PRU_T_WR = 3'h3;
   localparam logic [2:0] PRU_T_REGISTER = 3'h4;
   localparam logic [4:0] PRU_TOTAL_REG = 5'h08;
   localparam logic [4:0] PRU_TOTAL_PAIR = 5'h0f;
   localparam logic [4:0] PRU_TOTAL_IDX = 5'h17;
   typedef enum logic [1:0] {
      PRU_KIND_RLC = 2'h0,
      PRU_KIND_RL = 2'h1,
      PRU_KIND_RRC = 2'h2,
      PRU_KIND_BAD = 2'h3
   } pru_kind_e;
endpackage : pru_pkg
`default_nettype wire

// ### src/pru_rotate.sv
// combinational rotate and flag generator
`default_nettype none
module pru_rotate (
   input wire logic [1:0] kind,
   input wire logic [7:0] operand,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic [7:0] flags
);
   always_comb begin
      unique case (pru_pkg::pru_kind_e'(kind))
         pru_pkg::PRU_KIND_RLC: result = {operand[6:0], operand[7]};
         pru_pkg::PRU_KIND_RL: result = {operand[6:0], carry_in};
         pru_pkg::PRU_KIND_RRC: result = {operand[0], operand[7:1]};
         default: result = operand;
      endcase
   end
   always_comb begin
      flags = 8'h00;
      flags[pru_pkg::PRU_F_S] = result[7];
      flags[pru_pkg::PRU_F_Z] = (result == 8'h00);
      flags[pru_pkg::PRU_F_PV] = ~^result;
      flags[pru_pkg::PRU_F_H] = 1'b0;
      flags[pru_pkg::PRU_F_N] = 1'b0;
      flags[pru_pkg::PRU_F_C] = (kind == 2'h2) ? operand[0] : operand[7];
   end
endmodule // pru_rotate
`default_nettype wire

// ### src/pru_state_timer.sv
// counts clock states inside one machine cycle
`default_nettype none
module pru_state_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [2:0] length,
   output logic last
);
   logic [2:0] cnt_r;
   always_ff @(posedge clk) begin
      if (rst || start) begin
         cnt_r <= 3'h1;
      end else if (!last) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end
   assign last = (cnt_r >= length);
endmodule // pru_state_timer
`default_nettype wire

// ### src/pru_top.sv
// prefixed rotate unit: fetch, decode, execute, write back
`default_nettype none
module pru_top (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic START,
   input wire logic [15:0] IDX1,
   input wire logic [15:0] IDX2,
   input wire logic [15:0] PAIR,
   input wire logic [63:0] REGS,
   input wire logic CARRY_IN,
   input wire logic [7:0] MEM_RDATA,
   output logic [15:0] MEM_ADDR,
   output logic MEM_RD,
   output logic MEM_WR,
   output logic [7:0] MEM_WDATA,
   output logic REG_WE,
   output logic [2:0] REG_SEL,
   output logic [7:0] REG_WDATA,
   output logic [7:0] FLAGS,
   output logic FLAGS_WE,
   output logic [15:0] PC,
   output logic BUSY,
   output logic DONE,
   output logic ILLEGAL,
   output logic [4:0] STATES
);
   // each machine cycle runs a fixed count of clock states
   typedef enum logic [3:0] {
      PRU_IDLE = 4'h0,
      PRU_FETCH1 = 4'h1,
      PRU_FETCH2 = 4'h3,
      PRU_DISP = 4'h2,
      PRU_ADDCALC = 4'h6,
      PRU_READ = 4'h5,
      PRU_WRITE = 4'h4,
      PRU_FIN = 4'hc
   } pru_state_e;

   pru_state_e st_r;
   logic [1:0] pfx_r;
   logic [15:0] pc_r;
   logic [15:0] ea_r;
   logic [7:0] disp_r;
   logic [7:0] op_r;
   logic [7:0] data_r;
   logic [4:0] states_r;
   logic tm_start;
   logic tm_last;
   logic [2:0] tm_len;
   logic [1:0] kind;
   logic [7:0] rot_res;
   logic [7:0] rot_flags;
   logic [7:0] operand;

   function automatic logic [1:0] op_kind(input logic [7:0] op);
      unique case (op[7:3])
         pru_pkg::PRU_OP_RLC: op_kind = pru_pkg::PRU_KIND_RLC;
         pru_pkg::PRU_OP_RL: op_kind = pru_pkg::PRU_KIND_RL;
         pru_pkg::PRU_OP_RRC: op_kind = pru_pkg::PRU_KIND_RRC;
         default: op_kind = pru_pkg::PRU_KIND_BAD;
      endcase
   endfunction

   assign kind = op_kind(op_r);
   assign operand = (pfx_r == 2'h0 && op_r[2:0] != pru_pkg::PRU_REG_MEM) ?
                    REGS[op_r[2:0]*8 +: 8] : data_r;

   pru_rotate u_rot (
      .kind(kind),
      .operand(operand),
      .carry_in(CARRY_IN),
      .result(rot_res),
      .flags(rot_flags)
   );

   always_comb begin
      unique case (st_r)
         PRU_DISP: tm_len = pru_pkg::PRU_T_MEMRD;
         // the opcode byte of the index forms is read during the add
         PRU_ADDCALC: tm_len = pru_pkg::PRU_T_DISP_ADD;
         // operand read is four states in both memory forms
         PRU_READ: tm_len = pru_pkg::PRU_T_PAIR_RD;
         PRU_WRITE: tm_len = pru_pkg::PRU_T_WR;
         default: tm_len = pru_pkg::PRU_T_M1;
      endcase
   end

   logic adv;
   assign adv = tm_last && st_r != PRU_IDLE && st_r != PRU_FIN;
   assign tm_start = (st_r == PRU_IDLE && START) || adv;

   // every state that consumes an instruction byte
   logic fetching;
   assign fetching = st_r == PRU_FETCH1 || st_r == PRU_FETCH2 || st_r == PRU_DISP ||
                     st_r == PRU_ADDCALC;

   pru_state_timer u_tm (
      .clk(REF_CLK),
      .rst(RST),
      .start(tm_start),
      .length(tm_len),
      .last(tm_last)
   );

   // sequencing of machine cycles
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         st_r <= PRU_IDLE;
      end else begin
         unique case (st_r)
            PRU_IDLE: if (START) st_r <= PRU_FETCH1;
            PRU_FETCH1: if (tm_last) begin
               if (MEM_RDATA == pru_pkg::PRU_PFX_CB) begin
                  st_r <= PRU_FETCH2;
               end else if (MEM_RDATA == pru_pkg::PRU_PFX_IX ||
                            MEM_RDATA == pru_pkg::PRU_PFX_IY) begin
                  st_r <= PRU_FETCH2;
               end else begin
                  st_r <= PRU_FIN;
               end
            end
            PRU_FETCH2: if (tm_last) begin
               if (pfx_r != 2'h0) begin
                  st_r <= (MEM_RDATA == pru_pkg::PRU_PFX_CB) ? PRU_DISP : PRU_FIN;
               end else if (op_kind(MEM_RDATA) == pru_pkg::PRU_KIND_BAD) begin
                  st_r <= PRU_FIN;
               end else if (MEM_RDATA[2:0] == pru_pkg::PRU_REG_MEM) begin
                  // pair form goes straight to the operand read
                  st_r <= PRU_READ;
               end else begin
                  st_r <= PRU_FIN;
               end
            end
            PRU_DISP: if (tm_last) st_r <= PRU_ADDCALC;
            // opcode byte arrives at the end of the add cycle
            PRU_ADDCALC: if (tm_last) begin
               st_r <= (op_kind(MEM_RDATA) == pru_pkg::PRU_KIND_BAD ||
                        MEM_RDATA[2:0] != pru_pkg::PRU_REG_MEM) ? PRU_FIN : PRU_READ;
            end
            PRU_READ: if (tm_last) st_r <= PRU_WRITE;
            PRU_WRITE: if (tm_last) st_r <= PRU_FIN;
            PRU_FIN: st_r <= PRU_IDLE;
            default: st_r <= PRU_IDLE;
         endcase
      end
   end

   // prefix and opcode capture
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         pfx_r <= 2'h0;
         op_r <= 8'h00;
         disp_r <= 8'h00;
      end else begin
         if (st_r == PRU_IDLE && START) begin
            pfx_r <= 2'h0;
         end
         if (st_r == PRU_FETCH1 && tm_last) begin
            pfx_r <= (MEM_RDATA == pru_pkg::PRU_PFX_IX) ? 2'h1 :
                     (MEM_RDATA == pru_pkg::PRU_PFX_IY) ? 2'h2 : 2'h0;
         end
         if (st_r == PRU_FETCH2 && tm_last && pfx_r == 2'h0) begin
            op_r <= MEM_RDATA;
         end
         if (st_r == PRU_DISP && tm_last) begin
            disp_r <= MEM_RDATA;
         end
         if (st_r == PRU_ADDCALC && tm_last && pfx_r != 2'h0) begin
            op_r <= MEM_RDATA;
         end
      end
   end

   // address generation and read data
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ea_r <= pru_pkg::PRU_PTR_RST;
         data_r <= 8'h00;
      end else begin
         if (st_r == PRU_ADDCALC && tm_last) begin
            ea_r <= ((pfx_r == 2'h1) ? IDX1 : IDX2) + {{8{disp_r[7]}}, disp_r};
         end else if (st_r == PRU_FETCH2 && pfx_r == 2'h0) begin
            ea_r <= PAIR;
         end
         if (st_r == PRU_READ && tm_last) begin
            data_r <= MEM_RDATA;
         end
      end
   end

   // bus outputs, all registered
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         MEM_ADDR <= pru_pkg::PRU_PTR_RST;
         MEM_RD <= 1'b0;
         MEM_WR <= 1'b0;
         MEM_WDATA <= 8'h00;
         pc_r <= pru_pkg::PRU_PTR_RST;
      end else begin
         MEM_RD <= 1'b0;
         MEM_WR <= 1'b0;
         if (st_r == PRU_IDLE && START) begin
            MEM_ADDR <= pc_r;
         end
         // address follows the new pointer, else a byte is read twice
         if (fetching && tm_last) begin
            pc_r <= pc_r + 16'h0001;
            MEM_ADDR <= pc_r + 16'h0001;
            MEM_RD <= 1'b1;
         end
         if (st_r == PRU_READ && tm_last) begin
            MEM_RD <= 1'b1;
         end
         if (st_r == PRU_WRITE) begin
            MEM_ADDR <= ea_r;
            MEM_WDATA <= rot_res;
            MEM_WR <= tm_last;
         end else if (st_r == PRU_READ) begin
            MEM_ADDR <= ea_r;
         end
      end
   end

   // result delivery and status
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         REG_WE <= 1'b0;
         REG_SEL <= 3'h0;
         REG_WDATA <= 8'h00;
         FLAGS <= pru_pkg::PRU_FLAGS_RST;
         FLAGS_WE <= 1'b0;
         DONE <= 1'b0;
         ILLEGAL <= 1'b0;
         BUSY <= 1'b0;
         STATES <= 5'h00;
         states_r <= 5'h00;
      end else begin
         REG_WE <= 1'b0;
         FLAGS_WE <= 1'b0;
         DONE <= 1'b0;
         BUSY <= (st_r != PRU_IDLE && st_r != PRU_FIN) || (st_r == PRU_IDLE && START);
         if (st_r == PRU_IDLE) begin
            states_r <= 5'h00;
         end else if (st_r != PRU_FIN) begin
            states_r <= states_r + 5'h01;
         end
         if (st_r == PRU_FETCH2 && tm_last && pfx_r == 2'h0 &&
             op_kind(MEM_RDATA) != pru_pkg::PRU_KIND_BAD &&
             MEM_RDATA[2:0] != pru_pkg::PRU_REG_MEM) begin
            REG_WE <= 1'b1;
            REG_SEL <= MEM_RDATA[2:0];
            REG_WDATA <= (op_kind(MEM_RDATA) == pru_pkg::PRU_KIND_RRC) ?
               {REGS[MEM_RDATA[2:0]*8], REGS[MEM_RDATA[2:0]*8+1 +: 7]} :
               (op_kind(MEM_RDATA) == pru_pkg::PRU_KIND_RL) ?
               {REGS[MEM_RDATA[2:0]*8 +: 7], CARRY_IN} :
               {REGS[MEM_RDATA[2:0]*8 +: 7], REGS[MEM_RDATA[2:0]*8+7]};
         end
         if (st_r == PRU_FIN) begin
            DONE <= 1'b1;
            STATES <= states_r;
            ILLEGAL <= !(REG_WE || MEM_WR);
         end
         if ((st_r == PRU_WRITE && tm_last) || (st_r == PRU_FIN && REG_WE)) begin
            FLAGS <= rot_flags;
            FLAGS_WE <= 1'b1;
         end
      end
   end

   assign PC = pc_r;
endmodule // pru_top
`default_nettype wire

// ### tb/pru_top_sva.sv
// checker for the prefixed rotate unit ports
`default_nettype none
module pru_top_chk (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic START,
   input wire logic MEM_RD,
   input wire logic MEM_WR,
   input wire logic [7:0] MEM_WDATA,
   input wire logic REG_WE,
   input wire logic [2:0] REG_SEL,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] FLAGS,
   input wire logic BUSY,
   input wire logic DONE,
   input wire logic ILLEGAL,
   input wire logic [4:0] STATES
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   logic [7:0] res_r;
   // last result written, for the flag relation
   always_ff @(posedge REF_CLK) begin
      if (RST) res_r <= 8'h00;
      else if (MEM_WR) res_r <= MEM_WDATA;
      else if (REG_WE) res_r <= REG_WDATA;
   end
   done_pulse_a: assert property (DONE |=> !DONE)
      else $error("done longer than one cycle");
   hn_clear_a: assert property (!FLAGS[4] && !FLAGS[1])
      else $error("half-carry or subtract set");
   flag_result_a: assert property (DONE && !ILLEGAL |-> ##2
      (FLAGS[7] == res_r[7] && FLAGS[6] == (res_r == 8'h00) && FLAGS[2] == ~^res_r))
      else $error("flags disagree with result");
   illegal_quiet_a: assert property (DONE && ILLEGAL |-> $past(!MEM_WR && !REG_WE))
      else $error("write during refused opcode");
   reg_sel_a: assert property (REG_WE |-> REG_SEL != 3'h6)
      else $error("memory code used as register");
   states_total_a: assert property (DONE && !ILLEGAL |-> STATES inside {5'h08, 5'h0f, 5'h17})
      else $error("state count wrong");
   done_bound_a: assert property ($rose(BUSY) |-> ##[6:26] DONE)
      else $error("instruction did not finish in time");
   rd_wr_excl_a: assert property (!(MEM_RD && MEM_WR))
      else $error("read and write together");
endmodule // pru_top_chk
bind pru_top pru_top_chk u_chk (.REF_CLK(REF_CLK), .RST(RST), .START(START), .MEM_RD(MEM_RD),
   .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .REG_WE(REG_WE), .REG_SEL(REG_SEL),
   .REG_WDATA(REG_WDATA), .FLAGS(FLAGS), .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL),
   .STATES(STATES));
`default_nettype wire

// ### tb/pru_mem_model.sv
// memory and fetch bus model for the rotate unit
`default_nettype none
module pru_mem_model (
   input wire logic clk,
   input wire logic [15:0] addr,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];
   // untouched cells hold the low address byte xor 5a, never a stale byte
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5a;
   end
   assign rdata = mem[addr];
   always @(posedge clk) begin
      if (wr) mem[addr] <= wdata;
   end
endmodule // pru_mem_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the prefixed rotate unit
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
$display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rst = 1'b1, start = 1'b0, cin = 1'b0;
   logic [15:0] idx1 = 16'h8000, idx2 = 16'h8000, pair = 16'h8000;
   logic [63:0] regs = 64'h0;
   logic [7:0] rdata, wdata, reg_wd, flags;
   logic [15:0] maddr, pc;
   logic mrd, mwr, reg_we, flags_we, busy, done, illegal;
   logic [2:0] reg_sel;
   logic [4:0] states;
   logic [31:0] seed = 32'hc56d;
   int n_fail = 0, num_checks = 0;
   always #2.5 ref_clk = ~ref_clk;
   pru_top u_pru_top (.REF_CLK(ref_clk), .RST(rst), .START(start), .IDX1(idx1), .IDX2(idx2),
      .PAIR(pair), .REGS(regs), .CARRY_IN(cin), .MEM_RDATA(rdata), .MEM_ADDR(maddr),
      .MEM_RD(mrd), .MEM_WR(mwr), .MEM_WDATA(wdata), .REG_WE(reg_we), .REG_SEL(reg_sel),
      .REG_WDATA(reg_wd), .FLAGS(flags), .FLAGS_WE(flags_we), .PC(pc), .BUSY(busy),
      .DONE(done), .ILLEGAL(illegal), .STATES(states));
   pru_mem_model u_pru_mem_model (.clk(ref_clk), .addr(maddr), .wr(mwr), .wdata(wdata),
      .rdata(rdata));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // carry out above the rotated byte
   function automatic logic [8:0] rot(input logic [4:0] op, input logic [7:0] v, input logic c);
      if (op == pru_pkg::PRU_OP_RLC) return {v[7], v[6:0], v[7]};
      if (op == pru_pkg::PRU_OP_RL) return {v[7], v[6:0], c};
      return {v[0], v[0], v[7:1]};
   endfunction
   task automatic conclude;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // form 0 register, 1 pair, 2 first index, 3 second index
   task automatic exec(input int form, input logic [4:0] op, input logic [2:0] r,
         input logic [7:0] v);
      logic [15:0] a, ea, p1, p2, p3;
      logic [7:0] d, ob;
      logic [8:0] e;
      logic [63:0] rv;
      logic bad, c, seen, fw;
      seed = lfsr(seed);
      d = seed[7:0];
      c = seed[8];
      p1 = {2'b10, seed[29:16]};
      seed = lfsr(seed);
      // pointers kept clear of the code area, even with a displacement
      p2 = {2'b10, seed[13:0]};
      p3 = {2'b10, seed[29:16]};
      rv = {seed, ~seed};
      rv[r*8+:8] = v;
      bad = op > pru_pkg::PRU_OP_RL;
      ob = {op, form == 0 ? r : pru_pkg::PRU_REG_MEM};
      ea = form == 2 ? p1 + {{8{d[7]}}, d} : form == 3 ? p2 + {{8{d[7]}}, d} : p3;
      e = rot(op, v, c);
      a = pc;
      if (form > 1) begin
         u_pru_mem_model.mem[a] = form == 2 ? pru_pkg::PRU_PFX_IX : pru_pkg::PRU_PFX_IY;
         a++;
      end
      u_pru_mem_model.mem[a] = pru_pkg::PRU_PFX_CB;
      if (form > 1) begin
         u_pru_mem_model.mem[a+1] = d;
         a++;
      end
      u_pru_mem_model.mem[a+1] = ob;
      if (form > 0) u_pru_mem_model.mem[ea] = v;
      @(posedge ref_clk);
      idx1 <= p1;
      idx2 <= p2;
      pair <= p3;
      regs <= rv;
      cin <= c;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      seen = 1'b0;
      fw = 1'b0;
      for (int n = 0; n < 40 && !seen; n++) begin
         @(posedge ref_clk);
         #1;
         if (reg_we) begin
            `CHK("reg_sel", r, reg_sel)
            `CHK("reg_data", e[7:0], reg_wd)
         end
         if (mwr) begin
            `CHK("mem_addr", ea, maddr)
            `CHK("mem_data", e[7:0], wdata)
         end
         if (bad) `CHK("refused_write", 1'b0, reg_we | mwr)
         fw = fw | flags_we;
         seen = done;
      end
      `CHK("done", 1'b1, seen)
      `CHK("flags_we", !bad, fw)
      `CHK("pc", a + 16'h0002, pc)
      `CHK("illegal", bad, illegal)
      if (!bad) `CHK("states", form == 0 ? 5'h08 : form == 1 ? 5'h0f : 5'h17, states)
      repeat (3) @(posedge ref_clk);
      #1;
      // bits 5 and 3 carry no defined meaning here
      if (!bad) `CHK("flags", {e[7], e[7:0] == 8'h00, 3'h0, ~^e[7:0], 1'b0, e[8]},
         flags & 8'hd7)
   endtask
   initial begin
      logic [7:0] corner [4] = '{8'h00, 8'h80, 8'h01, 8'hff};
      logic [4:0] ops [3] = '{pru_pkg::PRU_OP_RLC, pru_pkg::PRU_OP_RRC, pru_pkg::PRU_OP_RL};
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      `CHK("busy_after_reset", 1'b0, busy)
      `CHK("flags_after_reset", pru_pkg::PRU_FLAGS_RST, flags)
      for (int i = 0; i < 96; i++) begin
         seed = lfsr(seed);
         exec(i % 4, ops[(i / 4) % 3], (i / 12) % 8 == 6 ? 3'h7 : 3'((i / 12) % 8),
            i < 24 ? corner[i % 4] : seed[23:16]);
      end
      exec(0, 5'h03, 3'h2, 8'h5a);
      exec(2, 5'h1f, 3'h0, 8'ha5);
      exec(1, pru_pkg::PRU_OP_RL, 3'h0, 8'h7e);
      conclude();
   end
   initial begin
      repeat (8000) @(posedge ref_clk);
      n_fail++;
      conclude();
   end
endmodule // tb
`default_nettype wire
